// File: design/scc_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// RL1: done flag high after init and calibration
// RL2: user commands only while done flag high
// RL3: phy exchange on divide-by-four slow enable
// RL4: processor bus updates at most every three
// RL5: helper turns registered command into single-cycle issue
// RL6: helper repeats reads and compares data
// RL7: after reset start with skew self-check
// RL8: skew results kept for tracking
// RL9: memory init then datapath calibration after skew
// RL10: compute tracking offsets before completion
// RL11: user commands pass only after completion
// RL12: decode bus, translate, mux read data
// RL13: logical delay address mapped to pinout address
// RL14: per-pin access gives nibble and register address
// RL15: config rom steers initialization and calibration
// RL16: config pin low then pll lock wait
// RL17: done low in reset, sticky until reset
module scc_ctrl #(
  parameter int TPLL_CYCLES = scc_pkg::TPLL_CYC,
  parameter int SKEW_W      = 8
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // calibration processor i/o bus
  input  wire logic        io_strobe_i,
  input  wire logic        io_write_i,
  input  wire logic [27:0] io_addr_i,
  input  wire logic [31:0] io_wdata_i,
  output logic      [31:0] io_rdata_o,
  output logic             io_ready_o,
  // phy skew self-check and offsets
  output logic             skew_start_o,
  input  wire logic        skew_done_i,
  input  wire logic [SKEW_W-1:0] skew_value_i,
  output logic             offs_start_o,
  input  wire logic        offs_done_i,
  output logic [SKEW_W-1:0] track_skew_o,
  // phy register interface
  output logic      [5:0]  riu_addr_o,
  output logic      [4:0]  riu_nibble_o,
  output logic      [15:0] riu_wdata_o,
  output logic             riu_wr_o,
  // phy command issue and read return
  output logic             phy_cmd_valid_o,
  output logic      [7:0]  phy_cmd_o,
  input  wire logic        phy_rd_valid_i,
  input  wire logic [31:0] phy_rd_data_i,
  // memory configuration pin
  output logic             mem_cfg_n_o,
  // user command gate, slow enable and done flag
  input  wire logic        user_cmd_valid_i,
  output logic             user_cmd_valid_o,
  output logic             slow_en_o,
  output logic             calibration_done_flag_o
);

  // ---------------------------------------------------------------------------
  // slow-domain enable
  // ---------------------------------------------------------------------------
  logic [1:0] div_r;
  wire        slow_en = (div_r == 2'(scc_pkg::SLOW_DIV - 1));
  // divide-by-four enable instead of a derived clock [RL3]
  always_ff @(posedge clk_i) begin
    if (!rstn_i) div_r <= 2'h0;
    else         div_r <= div_r + 2'h1;
  end
  assign slow_en_o = slow_en;

  // ---------------------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------------------
  logic [1:0] gap_r;
  wire acc      = io_strobe_i && (gap_r == 2'h0);
  wire wr       = acc && io_write_i;
  wire sel_cmd  = (io_addr_i == scc_pkg::ADR_CMD);
  wire sel_rep  = (io_addr_i == scc_pkg::ADR_REPEAT);
  wire sel_exp  = (io_addr_i == scc_pkg::ADR_EXPECT);
  wire sel_stg  = (io_addr_i == scc_pkg::ADR_STAGE_DONE);
  wire sel_rom  = (io_addr_i[27:6] == scc_pkg::ADR_ROM_BASE[27:6]);  // 16 words, word aligned
  wire sel_pin  = (io_addr_i[27:3] == scc_pkg::ADR_ODLY_BASE[27:3]);
  // bus spacing guard: helper does fast work, bus may not [RL4]
  always_ff @(posedge clk_i) begin
    if (!rstn_i)  gap_r <= 2'h0;
    else if (acc) gap_r <= 2'(scc_pkg::IO_GAP - 1);
    else if (gap_r != 2'h0) gap_r <= gap_r - 2'h1;
  end

  // ---------------------------------------------------------------------------
  // configuration rom, run-time adjustable
  // ---------------------------------------------------------------------------
  logic [31:0] rom_r [scc_pkg::ROM_DEPTH];
  wire  [31:0] rom_rd = rom_r[io_addr_i[5:2]];
  // rom word 0 bit 0 skips the pll wait for faster bring-up [RL15]
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < scc_pkg::ROM_DEPTH; i++) rom_r[i] <= 32'h0;
    end else if (wr && sel_rom) begin
      rom_r[io_addr_i[5:2]] <= io_wdata_i;
    end
  end
  wire skip_pll = rom_r[0][0];

  // ---------------------------------------------------------------------------
  // pinout translation table, written at build per pinout
  // ---------------------------------------------------------------------------
  wire [2:0] pin = io_addr_i[2:0];
  logic [5:0] map_addr;
  logic [4:0] map_nib;
  // logical delay address to pinout-specific register address [RL13]
  always_comb begin
    map_addr = 6'hd + 6'(pin);
    map_nib  = 5'(pin[2]);
  end

  // per-pin access drives nibble and address to the phy bus [RL14]
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      riu_addr_o   <= 6'h0;
      riu_nibble_o <= 5'h0;
      riu_wdata_o  <= 16'h0;
      riu_wr_o     <= 1'b0;
    end else begin
      riu_wr_o <= wr && sel_pin;
      if (acc && sel_pin) begin
        riu_addr_o   <= map_addr;
        riu_nibble_o <= map_nib;
        riu_wdata_o  <= io_wdata_i[15:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // helper: single-cycle command issue with repeat and compare
  // ---------------------------------------------------------------------------
  logic [7:0]  cmd_r;
  logic [15:0] rep_r;
  logic [31:0] exp_r;
  logic        busy_r;
  logic        mism_r;
  logic [15:0] rdcnt_r;
  wire         issue = busy_r;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cmd_r  <= 8'h0;
      rep_r  <= 16'h0;
      exp_r  <= 32'h0;
      busy_r <= 1'b0;
    end else begin
      if (wr && sel_exp) exp_r <= io_wdata_i;
      if (wr && sel_rep) rep_r <= io_wdata_i[15:0];
      if (wr && sel_cmd && !busy_r) begin
        cmd_r  <= io_wdata_i[7:0];
        busy_r <= 1'b1;                           // issue next cycle [RL5]
      end else if (busy_r) begin
        if (rep_r == 16'h0) busy_r <= 1'b0;
        else rep_r <= rep_r - 16'h1;              // back-to-back repeats [RL6]
      end
    end
  end
  assign phy_cmd_valid_o = issue;
  assign phy_cmd_o       = cmd_r;

  // compare returned data; set wins over the clearing command write [RL6]
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mism_r  <= 1'b0;
      rdcnt_r <= 16'h0;
    end else if (phy_rd_valid_i) begin
      mism_r  <= (mism_r && !(wr && sel_cmd)) || (phy_rd_data_i != exp_r);
      rdcnt_r <= rdcnt_r + 16'h1;
    end else if (wr && sel_cmd) begin
      mism_r  <= 1'b0;
      rdcnt_r <= 16'h0;
    end
  end

  // ---------------------------------------------------------------------------
  // bring-up sequencer
  // ---------------------------------------------------------------------------
  scc_pkg::scc_state_t st_r, st_nxt;
  logic [15:0] tmr_r;
  logic        done_r;
  logic [SKEW_W-1:0] skew_r;
  wire stg_init = wr && sel_stg && (io_wdata_i[1:0] == scc_pkg::STG_INIT);
  wire stg_cal  = wr && sel_stg && (io_wdata_i[1:0] == scc_pkg::STG_CAL);
  wire tmr_zero = (tmr_r == 16'h0);

  // next-state selection
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      scc_pkg::SC_RESET: st_nxt = scc_pkg::SC_SKEW;                     // skew check first [RL7]
      scc_pkg::SC_SKEW:  if (skew_done_i) st_nxt = scc_pkg::SC_CFG;      // init waits for it [RL9]
      scc_pkg::SC_CFG:   if (tmr_zero && stg_init) st_nxt = scc_pkg::SC_PLL;
      scc_pkg::SC_PLL:   if (tmr_zero || skip_pll) st_nxt = scc_pkg::SC_CAL; // [RL16]
      scc_pkg::SC_CAL:   if (stg_cal) st_nxt = scc_pkg::SC_OFFS;          // [RL9]
      scc_pkg::SC_OFFS:  if (offs_done_i) st_nxt = scc_pkg::SC_DONE;      // [RL10]
      scc_pkg::SC_DONE:  st_nxt = scc_pkg::SC_DONE;
      default:           st_nxt = scc_pkg::SC_RESET;
    endcase
  end

  // state, timers, skew capture
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_r   <= scc_pkg::SC_RESET;
      tmr_r  <= 16'h0;
      skew_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (st_r == scc_pkg::SC_SKEW && skew_done_i) begin
        skew_r <= skew_value_i;                                      // held for tracking [RL8]
        tmr_r  <= 16'(scc_pkg::CFG_LOW_CYC);
      end else if (st_r == scc_pkg::SC_CFG && st_nxt == scc_pkg::SC_PLL) begin
        tmr_r  <= 16'(TPLL_CYCLES);
      end else if (!tmr_zero) begin
        tmr_r  <= tmr_r - 16'h1;
      end
    end
  end

  // sticky done flag [RL17]
  always_ff @(posedge clk_i) begin
    if (!rstn_i) done_r <= 1'b0;
    else if (st_r == scc_pkg::SC_DONE) done_r <= 1'b1;                 // [RL1]
  end

  assign skew_start_o            = (st_r == scc_pkg::SC_SKEW);
  assign offs_start_o            = (st_r == scc_pkg::SC_OFFS);
  assign track_skew_o            = skew_r;
  assign mem_cfg_n_o             = !(st_r == scc_pkg::SC_CFG);          // cfg low [RL16]
  assign calibration_done_flag_o = done_r;
  // early commands dropped, not queued [RL2] [RL11]
  assign user_cmd_valid_o        = user_cmd_valid_i && done_r;

  // ---------------------------------------------------------------------------
  // read-return multiplexer
  // ---------------------------------------------------------------------------
  wire [31:0] status = {16'(rdcnt_r), 7'h0, st_r, mism_r, done_r};
  logic [31:0] rd_mux;
  // return data chosen by decoded space [RL12]
  always_comb begin
    if (io_addr_i == scc_pkg::ADR_STATUS)      rd_mux = status;
    else if (io_addr_i == scc_pkg::ADR_RESULT) rd_mux = {15'h0, mism_r, rdcnt_r};
    else if (sel_rom)                          rd_mux = rom_rd;
    else if (sel_exp)                          rd_mux = exp_r;
    else if (sel_pin)                          rd_mux = {21'h0, map_nib, map_addr};
    else                                       rd_mux = 32'h0;
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      io_rdata_o <= 32'h0;
      io_ready_o <= 1'b0;
    end else begin
      io_ready_o <= acc;
      if (acc && !io_write_i) io_rdata_o <= rd_mux;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  sequence s_cal_end;
    (st_r == scc_pkg::SC_OFFS) ##1 (st_r == scc_pkg::SC_DONE);
  endsequence
  a_done_sticky: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RL17]
    done_r |=> done_r) else $error("done flag fell");
  a_done_after_offs: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RL10]
    s_cal_end |=> done_r) else $error("done not raised after offsets");
  a_done_cause: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RL1]
    $rose(done_r) |-> $past(st_r == scc_pkg::SC_DONE)) else $error("done without sequence");
  a_user_gate: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RL11]
    !done_r |-> !user_cmd_valid_o) else $error("command passed early");
  a_skew_first: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RL7]
    $past(!rstn_i) |=> st_r == scc_pkg::SC_SKEW) else $error("skew not first");
  a_cfg_order: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RL9]
    $rose(!mem_cfg_n_o) |-> $past(skew_done_i)) else $error("init before skew");
  a_div_rate: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RL3]
    slow_en |=> !slow_en [*3] ##1 slow_en) else $error("slow enable rate");
  a_bus_gap: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RL4]
    acc |=> !acc ##1 !acc) else $error("bus faster than three");
  a_cmd_single: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RL5]
    (wr && sel_cmd && !busy_r) |=> phy_cmd_valid_o) else $error("command not issued");
  a_riu_fwd: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RL14]
    (wr && sel_pin) |=> riu_wr_o && riu_addr_o == 6'hd + 6'($past(io_addr_i[2:0])))
    else $error("riu address wrong");
endmodule : scc_ctrl

// File: design/scc_pkg.sv
package scc_pkg;
  // ---------------------------------------------------------------------------
  // clocking and timing
  // ---------------------------------------------------------------------------
  localparam int          CLK_MHZ          = 200;
  localparam int          SLOW_DIV         = 4;                  // memory clock to fabric ratio
  localparam int          TPLL_US          = 20;                 // memory pll lock wait, microseconds
  localparam int          TPLL_CYC         = TPLL_US * CLK_MHZ;  // 4000 cycles
  localparam int          CFG_LOW_NS       = 100;                // config pin low time
  localparam int          CFG_LOW_CYC      = (CFG_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int          IO_GAP           = 3;                  // processor bus update spacing

  // ---------------------------------------------------------------------------
  // processor bus address map
  // ---------------------------------------------------------------------------
  localparam logic [27:0] ADR_STATUS       = 28'h0000000;
  localparam logic [27:0] ADR_CMD          = 28'h0000004;
  localparam logic [27:0] ADR_REPEAT       = 28'h0000008;
  localparam logic [27:0] ADR_EXPECT       = 28'h000000c;
  localparam logic [27:0] ADR_RESULT       = 28'h0000010;
  localparam logic [27:0] ADR_STAGE_DONE   = 28'h0000014;
  localparam logic [27:0] ADR_ROM_BASE     = 28'h0000200;
  localparam logic [27:0] ADR_ODLY_BASE    = 28'h0004100;
  localparam int          ROM_DEPTH        = 16;
  localparam int          PIN_COUNT        = 8;

  // ---------------------------------------------------------------------------
  // stage-done codes written by the processor
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  STG_INIT         = 2'h1;
  localparam logic [1:0]  STG_CAL          = 2'h2;

  // ---------------------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------------------
  typedef enum logic [6:0] {
    SC_RESET = 7'h01,
    SC_SKEW  = 7'h02,
    SC_CFG   = 7'h04,
    SC_PLL   = 7'h08,
    SC_CAL   = 7'h10,
    SC_OFFS  = 7'h20,
    SC_DONE  = 7'h40
  } scc_state_t;
endpackage : scc_pkg

// File: dv/scc_phy_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// phy stand-in: skew self-check, offsets and read return
// ---------------------------------------------------------------------------
module scc_phy_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // requests from the block
  input  wire logic        skew_start_i,
  input  wire logic        offs_start_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_i,
  // scenario knobs
  input  wire logic [3:0]  dly_i,
  input  wire logic [7:0]  skew_val_i,
  input  wire logic        corrupt_i,
  // answers to the block
  output logic             skew_done_o,
  output logic [7:0]       skew_value_o,
  output logic             offs_done_o,
  output logic             rd_valid_o,
  output logic [31:0]      rd_data_o
);
  logic [3:0]  cnt_r;
  logic        v1_r;
  logic [31:0] d1_r;

  // answers dly_i+1 cycles after the request rises; value lines toggle outside their strobe so stale data never looks valid
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_r        <= 4'h0;
      skew_done_o  <= 1'b0;
      offs_done_o  <= 1'b0;
      skew_value_o <= 8'h00;
      v1_r         <= 1'b0;
      rd_valid_o   <= 1'b0;
      rd_data_o    <= 32'h0;
    end else begin
      skew_done_o  <= 1'b0;
      offs_done_o  <= 1'b0;
      skew_value_o <= ~skew_value_o;
      cnt_r        <= (skew_start_i || offs_start_i) ? cnt_r + 4'h1 : 4'h0;
      if ((skew_start_i || offs_start_i) && cnt_r == dly_i) begin
        cnt_r        <= 4'h0;
        skew_done_o  <= skew_start_i;
        offs_done_o  <= offs_start_i;
        skew_value_o <= skew_val_i;
      end
      v1_r       <= cmd_valid_i;
      d1_r       <= {cmd_i, ~cmd_i, cmd_i, ~cmd_i} ^ {31'h0, corrupt_i}; // two-cycle read latency
      rd_valid_o <= v1_r;
      rd_data_o  <= v1_r ? d1_r : ~rd_data_o;
    end
  end
endmodule : scc_phy_model

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        clk_i, rstn_i, io_strobe_i, io_write_i, user_cmd_valid_i, corrupt, io_ready_o, riu_wr_o;
  logic        skew_done_i, offs_done_i, phy_rd_valid_i, skew_start_o, offs_start_o, phy_cmd_valid_o;
  logic        mem_cfg_n_o, user_cmd_valid_o, slow_en_o, calibration_done_flag_o;
  logic [27:0] io_addr_i;
  logic [31:0] io_wdata_i, io_rdata_o, phy_rd_data_i, w, q;
  logic [7:0]  skew_value_i, track_skew_o, phy_cmd_o, skew_val, c;
  logic [5:0]  riu_addr_o;
  logic [4:0]  riu_nibble_o;
  logic [15:0] riu_wdata_o;
  logic [3:0]  dly;
  logic [26:0] riu_seen;
  int          n_errors, cmp_count, slow_n, cmd_n, cfg_n, p, k, r, n0;
  wire  [3:0]  mon = {calibration_done_flag_o, offs_start_o, mem_cfg_n_o, phy_cmd_valid_o};

  scc_ctrl #(.TPLL_CYCLES(10), .SKEW_W(8)) u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .io_strobe_i(io_strobe_i), .io_write_i(io_write_i), .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .io_ready_o(io_ready_o), .skew_start_o(skew_start_o),
    .skew_done_i(skew_done_i), .skew_value_i(skew_value_i), .offs_start_o(offs_start_o),
    .offs_done_i(offs_done_i), .track_skew_o(track_skew_o), .riu_addr_o(riu_addr_o),
    .riu_nibble_o(riu_nibble_o), .riu_wdata_o(riu_wdata_o), .riu_wr_o(riu_wr_o),
    .phy_cmd_valid_o(phy_cmd_valid_o), .phy_cmd_o(phy_cmd_o), .phy_rd_valid_i(phy_rd_valid_i),
    .phy_rd_data_i(phy_rd_data_i), .mem_cfg_n_o(mem_cfg_n_o), .user_cmd_valid_i(user_cmd_valid_i),
    .user_cmd_valid_o(user_cmd_valid_o), .slow_en_o(slow_en_o), .calibration_done_flag_o(calibration_done_flag_o));

  scc_phy_model u_phy (
    .clk_i(clk_i), .rstn_i(rstn_i), .skew_start_i(skew_start_o), .offs_start_i(offs_start_o),
    .cmd_valid_i(phy_cmd_valid_o), .cmd_i(phy_cmd_o), .dly_i(dly), .skew_val_i(skew_val), .corrupt_i(corrupt),
    .skew_done_o(skew_done_i), .skew_value_o(skew_value_i), .offs_done_o(offs_done_i),
    .rd_valid_o(phy_rd_valid_i), .rd_data_o(phy_rd_data_i));

  // ---------------------------------------------------------------------------
  // clock, monitors and helpers
  // ---------------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // edge counters; pulses are caught here so no task has to hit the exact cycle
  always @(posedge clk_i) begin
    slow_n <= slow_n + int'(slow_en_o);
    cmd_n  <= cmd_n + int'(phy_cmd_valid_o);
    cfg_n  <= cfg_n + int'(!mem_cfg_n_o);
    if (!rstn_i) begin
      riu_seen <= '0;
    end else if (riu_wr_o === 1'b1) begin
      riu_seen <= {riu_addr_o, riu_nibble_o, riu_wdata_o};
    end
  end

  task tally_and_finish;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask : chk

  task bail;
    n_errors++;
    tally_and_finish();
  endtask : bail

  task step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task wait_bit(input int b, input logic lvl);
    int i;
    for (i = 0; i < 300 && mon[b] !== lvl; i++) step(1);
    if (mon[b] !== lvl) bail();
  endtask : wait_bit

  // one access; hog keeps strobing inside the gap, which must go unanswered
  task io(input logic wr, input logic [27:0] a, input logic [31:0] d, input logic hog, output logic [31:0] rd);
    int i;
    io_strobe_i = 1'b1;
    io_write_i  = wr;
    io_addr_i   = a;
    io_wdata_i  = d;
    for (i = 0; i < 8 && io_ready_o !== 1'b1; i++) @(posedge clk_i);
    if (io_ready_o !== 1'b1) bail();
    rd = io_rdata_o;
    #1;
    io_wdata_i  = ~d;
    io_strobe_i = hog;
    step(1);
    // hog strobe sat inside the gap: no answer may follow it
    if (hog) begin
      chk("refused", 0, io_ready_o);
      io_strobe_i = 1'b0;
      step(1);
    end
  endtask : io

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h998a757e));
    {rstn_i, io_strobe_i, io_write_i, io_addr_i, io_wdata_i, corrupt} = '0;
    {n_errors, cmp_count} = '0;
    user_cmd_valid_i = 1'b1;
    dly = 4'($urandom_range(2, 9));
    skew_val = 8'($urandom);
    repeat (4) @(posedge clk_i);
    #1;
    chk("done_in_reset", 0, calibration_done_flag_o);
    chk("cfg_in_reset", 1, mem_cfg_n_o);
    rstn_i = 1'b1;
    step(1);
    chk("skew_first", 1, skew_start_o);
    chk("cfg_after_skew", 1, mem_cfg_n_o);
    chk("gate_early", 0, user_cmd_valid_o);
    n0 = slow_n;
    step(16);
    chk("slow_en", 4, slow_n - n0);
    chk("skew_kept", skew_val, track_skew_o);
    chk("cfg_low", 0, mem_cfg_n_o);
    // rom word 0 bit 0 set: the pll wait must be skipped later
    io(1'b1, scc_pkg::ADR_ROM_BASE, 32'h1, 1'b0, q);
    // init-done before the minimum low time is dropped, pin stays low
    io(1'b1, scc_pkg::ADR_STAGE_DONE, 32'(scc_pkg::STG_INIT), 1'b0, q);
    chk("cfg_hold", 0, mem_cfg_n_o);
    for (p = 0; p < 300 && cfg_n < scc_pkg::CFG_LOW_CYC; p++) step(1);
    if (cfg_n < scc_pkg::CFG_LOW_CYC) bail();
    io(1'b1, scc_pkg::ADR_STAGE_DONE, 32'(scc_pkg::STG_INIT), 1'b0, q);
    wait_bit(1, 1'b1);
    chk("cfg_len", scc_pkg::CFG_LOW_CYC + 1, cfg_n);
    io(1'b0, scc_pkg::ADR_STATUS, 32'h0, 1'b0, q);
    chk("pll_skip", 32'(scc_pkg::SC_CAL), q[8:2]);
    // per-pin delay access, every pin
    for (p = 0; p < scc_pkg::PIN_COUNT; p++) begin
      w = $urandom;
      io(1'b1, scc_pkg::ADR_ODLY_BASE + 28'(p), w, 1'b0, q);
      step(1);
      chk("riu", {6'h0d + 6'(p), 5'(p / 4), w[15:0]}, 32'(riu_seen));
    end
    w = $urandom;
    io(1'b1, scc_pkg::ADR_ROM_BASE + 28'h4, w, 1'b1, q);
    io(1'b0, scc_pkg::ADR_ROM_BASE + 28'h4, 32'h0, 1'b0, q);
    chk("rom", w, q);
    // repeated reads: clean run then a corrupted single read
    for (k = 0; k < 2; k++) begin
      c = 8'($urandom);
      r = k ? 0 : $urandom_range(1, 5);
      corrupt = k[0];
      io(1'b1, scc_pkg::ADR_EXPECT, {c, ~c, c, ~c}, 1'b0, q);
      io(1'b1, scc_pkg::ADR_REPEAT, 32'(r), 1'b0, q);
      n0 = cmd_n;
      io(1'b1, scc_pkg::ADR_CMD, 32'(c), 1'b0, q);
      wait_bit(0, 1'b0);
      step(4);
      chk("burst_len", r + 1, cmd_n - n0);
      io(1'b0, scc_pkg::ADR_RESULT, 32'h0, 1'b0, q);
      chk("result", {15'h0, k[0], 16'(r + 1)}, q);
    end
    corrupt = 1'b0;
    chk("done_before_cal", 0, calibration_done_flag_o);
    io(1'b1, scc_pkg::ADR_STAGE_DONE, 32'(scc_pkg::STG_CAL), 1'b0, q);
    wait_bit(2, 1'b1);
    chk("done_during_offs", 0, calibration_done_flag_o);
    wait_bit(3, 1'b1);
    chk("gate_open", 1, user_cmd_valid_o);
    io(1'b0, scc_pkg::ADR_STATUS, 32'h0, 1'b0, q);
    chk("status", {scc_pkg::SC_DONE, 1'b1}, {q[8:2], q[0]});
    step(20);
    chk("done_sticky", 1, calibration_done_flag_o);
    rstn_i = 1'b0;
    step(1);
    chk("done_cleared", 0, calibration_done_flag_o);
    rstn_i = 1'b1;
    step(1);
    chk("skew_again", 1, skew_start_o);
    tally_and_finish();
  end

  // hang guard
  initial begin
    #200000;
    bail();
  end
endmodule : testbench
